// >>> rtl/adc_port_device.sv
`timescale 1ns/1ps
module adc_port_device (
  // clocks and reset
  input  wire logic                              clk_sys,
  input  wire logic                              srst,
  input  wire logic                              clk_link,
  // mode strap
  input  wire logic                              mode,
  // serial link
  adc_link_if.device                             link,
  // converter side, clk_sys domain
  input  wire logic                              conv_valid,
  input  wire logic [adc_link_pkg::WORD_BITS-1:0] conv_word,
  input  wire logic                              conv_long,
  input  wire logic                              cal_access,
  // stored registers, clk_link domain
  output logic      [adc_link_pkg::WORD_BITS-1:0] ctrl_reg,
  output logic      [adc_link_pkg::WORD_BITS-1:0] cal_reg
);
  import adc_link_pkg::*;

  // ----------------------------------------------------------------
  // reset into the link domain
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic       lrst;

  always_ff @(posedge clk_link) begin
    rst_sync_ff <= {rst_sync_ff[0], srst};
  end
  assign lrst = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // conversion word hand-off, clk_sys side
  // ----------------------------------------------------------------
  // word is held stable until the next valid; toggle marks the event
  logic [23:0] conv_hold_ff;
  logic        conv_long_ff;
  logic        conv_tog_ff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      conv_hold_ff <= 24'h000000;
      conv_long_ff <= 1'b0;
      conv_tog_ff  <= 1'b0;
    end else if (conv_valid) begin
      conv_hold_ff <= conv_word;
      conv_long_ff <= conv_long;
      conv_tog_ff  <= ~conv_tog_ff;
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] sync_in;
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic [7:0] sync3_ff;

  assign sync_in = {conv_tog_ff, cal_access, mode, link.sclk, link.sdata,
                    link.read_frame_n, link.write_frame_n, link.register_select};

  generate
    for (genvar i = 0; i < 8; i++) begin : g_sync
      always_ff @(posedge clk_link) begin
        if (lrst) begin
          sync1_ff[i] <= D_SYNC_RST[i];
          sync2_ff[i] <= D_SYNC_RST[i];
          sync3_ff[i] <= D_SYNC_RST[i];
        end else begin
          sync1_ff[i] <= sync_in[i];
          sync2_ff[i] <= sync1_ff[i];
          sync3_ff[i] <= sync2_ff[i];
        end
      end
    end
  endgenerate

  logic self_mode;
  logic word_evt;
  logic rfs_fall;
  logic tfs_fall;
  logic frame_low;

  assign self_mode = sync2_ff[D_MODE];
  assign word_evt  = sync2_ff[D_TOG] ^ sync3_ff[D_TOG];
  assign rfs_fall  = sync3_ff[D_RFS] & ~sync2_ff[D_RFS];
  assign tfs_fall  = sync3_ff[D_TFS] & ~sync2_ff[D_TFS];

  // ----------------------------------------------------------------
  // serial clock events
  // ----------------------------------------------------------------
  link_state_type state_ff;
  logic [4:0]     div_ff;
  logic           sclk_gen_ff;
  logic           div_wrap;
  logic           ext_rise;
  logic           ext_fall;
  logic           clk_rise;
  logic           clk_fall;

  assign div_wrap = (div_ff == DEV_HALF_CYC - 5'h01);
  assign ext_rise = sync2_ff[D_SCLK] & ~sync3_ff[D_SCLK];
  assign ext_fall = ~sync2_ff[D_SCLK] & sync3_ff[D_SCLK];
  assign frame_low = (state_ff == LK_READ) ? ~sync2_ff[D_RFS] : ~sync2_ff[D_TFS];
  // external rising clock edges only count while the frame is held low; falling edges always count
  assign clk_rise = self_mode ? (div_wrap & ~sclk_gen_ff) : (ext_rise & frame_low);
  assign clk_fall = self_mode ? (div_wrap & sclk_gen_ff) : ext_fall;

  // own clock starts low: MSB gets a half period of setup
  always_ff @(posedge clk_link) begin
    if (lrst || !self_mode || state_ff == LK_IDLE) begin
      div_ff      <= 5'h00;
      sclk_gen_ff <= 1'b0;
    end else if (div_wrap) begin // RQ1 RQ12 RQ16
      div_ff      <= 5'h00;
      sclk_gen_ff <= ~sclk_gen_ff;
    end else begin
      div_ff <= div_ff + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // output data register and ready flag
  // ----------------------------------------------------------------
  logic [23:0] out_reg_ff;
  logic        out_long_ff;
  logic        rdy_n_ff;
  logic        src_out_ff;
  logic [4:0]  bits_ff;
  logic        out_reading;
  logic        last_fall;

  assign out_reading = (state_ff == LK_READ) && src_out_ff;
  assign last_fall   = clk_fall && (bits_ff == BITS_NONE);

  always_ff @(posedge clk_link) begin
    if (lrst) begin
      out_reg_ff  <= 24'h000000;
      out_long_ff <= 1'b0;
    end else if (word_evt && !out_reading) begin // RQ7 RQ8
      out_reg_ff  <= conv_hold_ff;
      out_long_ff <= conv_long_ff;
    end
  end

  always_ff @(posedge clk_link) begin
    if (lrst) begin
      rdy_n_ff <= 1'b1;
    end else if (out_reading && last_fall) begin
      rdy_n_ff <= 1'b1; // RQ6 RQ14
    end else if (word_evt && !out_reading) begin
      rdy_n_ff <= 1'b0; // RQ5 RQ7
    end
  end

  // ----------------------------------------------------------------
  // transfer engine
  // ----------------------------------------------------------------
  logic [23:0] shreg_ff;
  logic        wr_sel_ff;

  always_ff @(posedge clk_link) begin
    if (lrst) begin
      state_ff   <= LK_IDLE;
      bits_ff    <= BITS_NONE;
      shreg_ff   <= 24'h000000;
      src_out_ff <= 1'b0;
      wr_sel_ff  <= 1'b0;
    end else begin
      unique case (state_ff)
        LK_IDLE: begin
          src_out_ff <= 1'b0;
          if (rfs_fall) begin
            if (!sync2_ff[D_SEL]) begin // RQ3
              shreg_ff <= ctrl_reg;
              bits_ff  <= BITS_LONG;
              state_ff <= LK_READ;
            end else if (sync2_ff[D_CAL]) begin // RQ20
              shreg_ff <= cal_reg;
              bits_ff  <= BITS_LONG;
              state_ff <= LK_READ;
            end else if (!rdy_n_ff) begin // RQ10
              shreg_ff   <= out_long_ff ? out_reg_ff : {out_reg_ff[15:0], SHORT_PAD};
              bits_ff    <= out_long_ff ? BITS_LONG : BITS_SHORT;
              src_out_ff <= 1'b1;
              state_ff   <= LK_READ;
            end
          end else if (tfs_fall) begin
            wr_sel_ff <= sync2_ff[D_SEL];
            bits_ff   <= BITS_LONG; // RQ15
            state_ff  <= LK_WRITE;
          end
        end
        LK_READ: begin
          if (clk_rise && bits_ff != BITS_NONE) begin
            bits_ff <= bits_ff - 5'h01;
          end else if (last_fall) begin
            state_ff <= LK_IDLE; // RQ14
          end else if (clk_fall) begin
            shreg_ff <= {shreg_ff[22:0], 1'b0}; // RQ13
          end
        end
        LK_WRITE: begin
          if (clk_rise && bits_ff != BITS_NONE) begin // RQ17
            shreg_ff <= {shreg_ff[22:0], sync2_ff[D_SDAT]};
            bits_ff  <= bits_ff - 5'h01;
          end else if (last_fall) begin
            state_ff <= LK_IDLE; // RQ18
          end
        end
        default: begin
          state_ff <= LK_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // stored registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_link) begin
    if (lrst) begin
      ctrl_reg <= CTRL_RST;
      cal_reg  <= CAL_RST;
    end else if (state_ff == LK_WRITE && last_fall) begin
      if (wr_sel_ff) begin // RQ19
        cal_reg <= shreg_ff;
      end else begin
        ctrl_reg <= shreg_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  assign link.dev_sclk_o     = sclk_gen_ff;
  assign link.dev_sclk_oe    = self_mode && (state_ff != LK_IDLE); // RQ1 RQ2 RQ18
  assign link.dev_sdata_o    = shreg_ff[23]; // RQ12
  // external mode: data released while the read frame is high
  assign link.dev_sdata_oe   = (state_ff == LK_READ) && (self_mode || ~sync2_ff[D_RFS]);
  assign link.result_ready_n = rdy_n_ff;

endmodule // adc_port_device

// >>> rtl/adc_link_pkg.sv
// Summary of operation
// RQ1: mode high: device makes serial clock
// RQ2: mode low: host supplies serial clock
// RQ3: read select high: output/cal, low: control
// RQ4: host holds register select steady per transfer
// RQ5: new conversion word drives ready low
// RQ6: ready high after last output bit
// RQ7: unread: ready stays low, newest word kept
// RQ8: word arriving during output read is dropped
// RQ9: control/cal reads leave ready untouched
// RQ10: read frame with ready high: no transfer
// RQ11: host reads 24 bits, ignores ready (host reads cmd_bits bits)
// RQ12: read frame fall starts clock, shows MSB
// RQ13: read bits change on falling clock edge
// RQ14: fall after LSB: ready high, outputs off
// RQ15: writes: 24 bits, control/cal, ready untouched
// RQ16: write frame fall starts own clock
// RQ17: write bits taken on rising edge, MSB first
// RQ18: clock off after fall past last bit
// RQ19: write select low: control, high: cal
// RQ20: select high: output/cal chosen by setting
package adc_link_pkg;

  // ----------------------------------------------------------------
  // word sizes
  // ----------------------------------------------------------------
  localparam int        WORD_BITS  = 24;
  localparam int        CNT_W      = 5;
  localparam logic [4:0] BITS_LONG  = 5'h18;
  localparam logic [4:0] BITS_SHORT = 5'h10;
  localparam logic [4:0] BITS_NONE  = 5'h00;
  localparam logic [7:0] SHORT_PAD  = 8'h00;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] CTRL_RST = 24'h000000;
  localparam logic [23:0] CAL_RST  = 24'h000000;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  // half period of the self-made serial clock, in clk_link cycles
  localparam logic [4:0] DEV_HALF_CYC  = 5'h18;
  // half period of the host-made serial clock, in clk_sys cycles
  localparam logic [7:0] HOST_HALF_CYC = 8'h04;
  // host gives up after this many clk_sys cycles without a clock edge
  localparam logic [7:0] HOST_WAIT_CYC = 8'hff;

  // ----------------------------------------------------------------
  // device synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int D_TOG  = 7;
  localparam int D_CAL  = 6;
  localparam int D_MODE = 5;
  localparam int D_SCLK = 4;
  localparam int D_SDAT = 3;
  localparam int D_RFS  = 2;
  localparam int D_TFS  = 1;
  localparam int D_SEL  = 0;
  localparam logic [7:0] D_SYNC_RST = 8'h0e;

  // ----------------------------------------------------------------
  // host synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int H_MODE = 3;
  localparam int H_SCLK = 2;
  localparam int H_SDAT = 1;
  localparam int H_RDY  = 0;
  localparam logic [3:0] H_SYNC_RST = 4'h3;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LK_IDLE  = 2'b00,
    LK_READ  = 2'b01,
    LK_WRITE = 2'b10
  } link_state_type;

  typedef enum logic {
    HS_IDLE  = 1'b0,
    HS_SHIFT = 1'b1
  } host_state_type;

endpackage

// >>> rtl/adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;
  logic dev_sclk_o;
  logic dev_sclk_oe;
  logic host_sclk_o;
  logic host_sclk_oe;
  logic dev_sdata_o;
  logic dev_sdata_oe;
  logic host_sdata_o;
  logic host_sdata_oe;
  logic read_frame_n;
  logic write_frame_n;
  logic register_select;
  logic result_ready_n;
  logic sclk;
  logic sdata;

  // released clock is pulled low so the final fall shows; data pulled up
  assign sclk  = dev_sclk_oe ? dev_sclk_o : (host_sclk_oe ? host_sclk_o : 1'b0);
  assign sdata = dev_sdata_oe ? dev_sdata_o : (host_sdata_oe ? host_sdata_o : 1'b1);

  modport device (
    input  sclk, sdata, read_frame_n, write_frame_n, register_select,
    output dev_sclk_o, dev_sclk_oe, dev_sdata_o, dev_sdata_oe, result_ready_n
  );

  modport host (
    input  sclk, sdata, result_ready_n,
    output host_sclk_o, host_sclk_oe, host_sdata_o, host_sdata_oe,
           read_frame_n, write_frame_n, register_select
  );
endinterface // adc_link_if

// >>> rtl/adc_port_host.sv
`timescale 1ns/1ps
module adc_port_host (
  // clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              srst,
  // mode strap
  input  wire logic                              mode,
  // serial link
  adc_link_if.host                               link,
  // command side
  input  wire logic                              cmd_read,
  input  wire logic                              cmd_write,
  input  wire logic                              cmd_sel,
  input  wire logic [adc_link_pkg::CNT_W-1:0]     cmd_bits,
  input  wire logic [adc_link_pkg::WORD_BITS-1:0] cmd_wdata,
  output logic                                   cmd_idle,
  // answer side
  output logic                                   rsp_valid,
  output logic                                   rsp_err,
  output logic      [adc_link_pkg::WORD_BITS-1:0] rsp_data,
  output logic                                   result_ready
);
  import adc_link_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync_in;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] sync3_ff;

  assign sync_in = {mode, link.sclk, link.sdata, link.result_ready_n};

  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          sync1_ff[i] <= H_SYNC_RST[i];
          sync2_ff[i] <= H_SYNC_RST[i];
          sync3_ff[i] <= H_SYNC_RST[i];
        end else begin
          sync1_ff[i] <= sync_in[i];
          sync2_ff[i] <= sync1_ff[i];
          sync3_ff[i] <= sync2_ff[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // clock events
  // ----------------------------------------------------------------
  host_state_type state_ff;
  logic [7:0]     cnt_ff;
  logic           hsclk_ff;
  logic           self_mode;
  logic           wrap;
  logic           rise;
  logic           fall;
  logic           stuck;

  assign self_mode = sync2_ff[H_MODE];
  assign wrap  = (cnt_ff == HOST_HALF_CYC - 8'h01);
  // synchronised sclk and sdata share latency, so sampling stays aligned
  assign rise  = self_mode ? (sync2_ff[H_SCLK] & ~sync3_ff[H_SCLK]) : (wrap & ~hsclk_ff);
  assign fall  = self_mode ? (~sync2_ff[H_SCLK] & sync3_ff[H_SCLK]) : (wrap & hsclk_ff);
  // a refused read never clocks; do not hang on it
  assign stuck = self_mode && (cnt_ff == HOST_WAIT_CYC);

  always_ff @(posedge clk_sys) begin
    if (srst || state_ff == HS_IDLE) begin
      cnt_ff   <= 8'h00;
      hsclk_ff <= 1'b0;
    end else if (self_mode) begin
      cnt_ff <= (rise || fall) ? 8'h00 : cnt_ff + 8'h01;
    end else if (wrap) begin // RQ2
      cnt_ff   <= 8'h00;
      hsclk_ff <= ~hsclk_ff;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // transfer engine
  // ----------------------------------------------------------------
  logic [23:0] shreg_ff;
  logic [4:0]  bits_ff;
  logic        is_write_ff;
  logic        rfs_n_ff;
  logic        tfs_n_ff;
  logic        sel_ff;

  assign cmd_idle = (state_ff == HS_IDLE);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff    <= HS_IDLE;
      shreg_ff    <= 24'h000000;
      bits_ff     <= BITS_NONE;
      is_write_ff <= 1'b0;
      rfs_n_ff    <= 1'b1;
      tfs_n_ff    <= 1'b1;
      sel_ff      <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_err     <= 1'b0;
      rsp_data    <= 24'h000000;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state_ff)
        HS_IDLE: begin
          if (cmd_write) begin
            sel_ff      <= cmd_sel; // RQ4
            shreg_ff    <= cmd_wdata;
            bits_ff     <= BITS_LONG; // RQ15
            is_write_ff <= 1'b1;
            tfs_n_ff    <= 1'b0;
            state_ff    <= HS_SHIFT;
          end else if (cmd_read) begin
            sel_ff      <= cmd_sel; // RQ4
            shreg_ff    <= 24'h000000;
            bits_ff     <= cmd_bits; // RQ11
            is_write_ff <= 1'b0;
            rfs_n_ff    <= 1'b0;
            state_ff    <= HS_SHIFT;
          end
        end
        HS_SHIFT: begin
          if (stuck) begin
            rfs_n_ff  <= 1'b1;
            tfs_n_ff  <= 1'b1;
            rsp_valid <= 1'b1;
            rsp_err   <= 1'b1;
            rsp_data  <= 24'h000000;
            state_ff  <= HS_IDLE;
          end else if (rise && bits_ff != BITS_NONE) begin // RQ17
            if (!is_write_ff) begin
              shreg_ff <= {shreg_ff[22:0], sync2_ff[H_SDAT]};
            end
            bits_ff <= bits_ff - 5'h01;
          end else if (fall && bits_ff == BITS_NONE) begin
            rfs_n_ff  <= 1'b1;
            tfs_n_ff  <= 1'b1;
            rsp_valid <= 1'b1;
            rsp_err   <= 1'b0;
            rsp_data  <= is_write_ff ? 24'h000000 : shreg_ff;
            state_ff  <= HS_IDLE;
          end else if (fall && is_write_ff) begin
            shreg_ff <= {shreg_ff[22:0], 1'b0};
          end
        end
        default: begin
          state_ff <= HS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  assign link.host_sclk_o     = hsclk_ff;
  // held low between transfers in external mode
  assign link.host_sclk_oe    = ~self_mode; // RQ2
  assign link.host_sdata_o    = shreg_ff[23];
  assign link.host_sdata_oe   = is_write_ff && (state_ff == HS_SHIFT);
  assign link.read_frame_n    = rfs_n_ff;
  assign link.write_frame_n   = tfs_n_ff;
  assign link.register_select = sel_ff;
  assign result_ready         = ~sync2_ff[H_RDY];

endmodule // adc_port_host

// >>> sim/adc_link_assertions.sv
`timescale 1ns/1ps
module adc_link_assertions (
  // clocks, reset, strap
  input wire logic clk_sys,
  input wire logic clk_link,
  input wire logic srst,
  input wire logic mode,
  // link signals
  input wire logic dev_sclk_oe,
  input wire logic dev_sdata_o,
  input wire logic dev_sdata_oe,
  input wire logic host_sclk_oe,
  input wire logic sclk,
  input wire logic read_frame_n,
  input wire logic write_frame_n,
  input wire logic register_select,
  input wire logic result_ready_n
);
  logic [2:0] age_ff;
  logic [5:0] rise_ff;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // host mode synchroniser is still settling just after reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      age_ff <= 3'h0;
    end else if (age_ff != 3'h7) begin
      age_ff <= age_ff + 3'h1;
    end
  end

  // rises of the self-made clock within one frame
  always_ff @(posedge clk_link) begin
    if (srst || !dev_sclk_oe) begin
      rise_ff <= 6'h00;
    end else if ($rose(sclk)) begin
      rise_ff <= rise_ff + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_rd_on;
    ##[1:6] (dev_sclk_oe && dev_sdata_oe && !sclk);
  endsequence
  sequence s_wr_on;
    ##[1:6] (dev_sclk_oe && !dev_sdata_oe && !sclk);
  endsequence

  property p_self_clk;
    @(posedge clk_sys) disable iff (srst) mode && age_ff == 3'h7 |-> !host_sclk_oe;
  endproperty
  property p_ext_clk;
    @(posedge clk_link) disable iff (srst) !mode [*4] |-> !dev_sclk_oe;
  endproperty
  property p_sel_steady;
    @(posedge clk_sys) disable iff (srst)
      (!read_frame_n || !write_frame_n) && $past(!read_frame_n || !write_frame_n)
      |-> $stable(register_select);
  endproperty
  property p_rd_start;
    @(posedge clk_link) disable iff (srst) $fell(read_frame_n) && mode && !dev_sclk_oe
      && (!register_select || !result_ready_n) |-> s_rd_on;
  endproperty
  property p_wr_start;
    @(posedge clk_link) disable iff (srst)
      $fell(write_frame_n) && mode && !dev_sclk_oe |-> s_wr_on;
  endproperty
  property p_data_on_low;
    @(posedge clk_link) disable iff (srst)
      dev_sdata_oe && $past(dev_sdata_oe) && $changed(dev_sdata_o) |-> !sclk;
  endproperty
  property p_rd_end;
    @(posedge clk_link) disable iff (srst)
      $rose(result_ready_n) |-> !dev_sdata_oe && !dev_sclk_oe;
  endproperty
  property p_clk_off;
    @(posedge clk_link) disable iff (srst)
      $fell(dev_sclk_oe) |-> $past(sclk) && !sclk && !dev_sdata_oe;
  endproperty
  property p_wr_flag;
    @(posedge clk_link) disable iff (srst) !write_frame_n |-> !$rose(result_ready_n);
  endproperty
  property p_ctl_flag;
    @(posedge clk_link) disable iff (srst)
      !read_frame_n && !register_select |-> !$rose(result_ready_n);
  endproperty
  property p_wr_len;
    @(posedge clk_link) disable iff (srst)
      $fell(dev_sclk_oe) && !write_frame_n |-> rise_ff == 6'h18;
  endproperty
  property p_rd_len;
    @(posedge clk_link) disable iff (srst) $fell(dev_sclk_oe) && !read_frame_n
      |-> rise_ff == 6'h18 || (register_select && rise_ff == 6'h10);
  endproperty

  a_self_clk: assert property (p_self_clk) else $error("host drove clock");
  a_ext_clk: assert property (p_ext_clk) else $error("device drove clock");
  a_sel_steady: assert property (p_sel_steady) else $error("select moved in frame");
  a_rd_start: assert property (p_rd_start) else $error("no read clock");
  a_wr_start: assert property (p_wr_start) else $error("no write clock");
  a_data_on_low: assert property (p_data_on_low) else $error("data moved with clock high");
  a_rd_end: assert property (p_rd_end) else $error("ready rose with outputs on");
  a_clk_off: assert property (p_clk_off) else $error("bad clock release");
  a_wr_flag: assert property (p_wr_flag) else $error("write raised ready");
  a_ctl_flag: assert property (p_ctl_flag) else $error("control read raised ready");
  a_wr_len: assert property (p_wr_len) else $error("write length wrong");
  a_rd_len: assert property (p_rd_len) else $error("read length wrong");
endmodule // adc_link_assertions

// >>> sim/adc_serial_port_self_clocked_test.sv
`timescale 1ns/1ps
module adc_serial_port_self_clocked_test;
  import adc_link_pkg::*;

  logic                 clk_sys, clk_link, srst, mode, conv_valid, conv_long, cal_access;
  logic                 cmd_read, cmd_write, cmd_sel, cmd_idle, rsp_valid, rsp_err, result_ready;
  logic [WORD_BITS-1:0] conv_word, ctrl_reg, cal_reg, cmd_wdata, rsp_data, got;
  logic [CNT_W-1:0]     cmd_bits;
  int                   fails;
  int                   check_count;

  // ----------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------
  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;
  initial #0.4 clk_link = 1'b0;
  always #3 clk_link = ~clk_link;

  adc_link_if u_adc_link_if ();

  adc_port_device u_adc_port_device (
    .clk_sys(clk_sys), .srst(srst), .clk_link(clk_link), .mode(mode), .link(u_adc_link_if),
    .conv_valid(conv_valid), .conv_word(conv_word), .conv_long(conv_long),
    .cal_access(cal_access), .ctrl_reg(ctrl_reg), .cal_reg(cal_reg)
  );

  adc_port_host u_adc_port_host (
    .clk_sys(clk_sys), .srst(srst), .mode(mode), .link(u_adc_link_if),
    .cmd_read(cmd_read), .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_bits(cmd_bits),
    .cmd_wdata(cmd_wdata), .cmd_idle(cmd_idle), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_data(rsp_data), .result_ready(result_ready)
  );

  adc_link_assertions u_adc_link_assertions (
    .clk_sys(clk_sys), .clk_link(clk_link), .srst(srst), .mode(mode),
    .dev_sclk_oe(u_adc_link_if.dev_sclk_oe), .dev_sdata_o(u_adc_link_if.dev_sdata_o),
    .dev_sdata_oe(u_adc_link_if.dev_sdata_oe), .host_sclk_oe(u_adc_link_if.host_sclk_oe),
    .sclk(u_adc_link_if.sclk), .read_frame_n(u_adc_link_if.read_frame_n),
    .write_frame_n(u_adc_link_if.write_frame_n),
    .register_select(u_adc_link_if.register_select),
    .result_ready_n(u_adc_link_if.result_ready_n)
  );

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic step(inout int n);
    cyc(1);
    n++;
    if (n > 4000) begin
      fails++;
      tally_and_finish;
    end
  endtask

  task automatic issue(input logic wr, input logic sel, input logic [4:0] bits,
                       input logic [23:0] wd);
    int n = 0;
    while (cmd_idle !== 1'b1) step(n);
    cmd_write = wr;
    cmd_read  = ~wr;
    cmd_sel   = sel;
    cmd_bits  = bits;
    cmd_wdata = wd;
    cyc(1);
    cmd_write = 1'b0;
    cmd_read  = 1'b0;
  endtask

  task automatic await_rsp;
    int n = 0;
    while (rsp_valid !== 1'b1) step(n);
    got = rsp_data;
    cyc(12);
  endtask

  task automatic xfer(input logic wr, input logic sel, input logic [4:0] bits,
                      input logic [23:0] wd);
    issue(wr, sel, bits, wd);
    await_rsp;
  endtask

  task automatic pulse(input logic [23:0] w);
    conv_word  = w;
    conv_valid = 1'b1;
    cyc(1);
    conv_valid = 1'b0;
    cyc(12);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic scn_write;
    xfer(1'b1, 1'b0, BITS_LONG, 24'ha5c3e1);
    check(ctrl_reg, 24'ha5c3e1);
    check(cal_reg, CAL_RST);
    xfer(1'b1, 1'b1, BITS_LONG, 24'h3c5a96);
    check(cal_reg, 24'h3c5a96);
    check(24'(result_ready), 24'h0);
  endtask

  task automatic scn_read;
    xfer(1'b0, 1'b0, BITS_LONG, 24'h0);
    check(got, 24'ha5c3e1);
    xfer(1'b0, 1'b1, BITS_LONG, 24'h0);
    check(24'(rsp_err), 24'h1);
    cal_access = 1'b1;
    cyc(4);
    xfer(1'b0, 1'b1, BITS_LONG, 24'h0);
    check(got, 24'h3c5a96);
    cal_access = 1'b0;
  endtask

  task automatic scn_output;
    pulse(24'h123456);
    check(24'(result_ready), 24'h1);
    pulse(24'hfedcba);
    xfer(1'b0, 1'b0, BITS_LONG, 24'h0);
    check(got, 24'ha5c3e1);
    check(24'(result_ready), 24'h1);
    xfer(1'b0, 1'b1, BITS_LONG, 24'h0);
    check(got, 24'hfedcba);
    check(24'(result_ready), 24'h0);
    conv_long = 1'b0;
    pulse(24'h9a7e51);
    xfer(1'b0, 1'b1, BITS_SHORT, 24'h0);
    check(got, 24'h007e51);
    check(24'(result_ready), 24'h0);
    conv_long = 1'b1;
  endtask

  // a word landing mid-read is lost and not flagged
  task automatic scn_dropped;
    pulse(24'h0f1e2d);
    issue(1'b0, 1'b1, BITS_LONG, 24'h0);
    cyc(60);
    pulse(24'h554433);
    await_rsp;
    check(got, 24'h0f1e2d);
    check(24'(result_ready), 24'h0);
  endtask

  task automatic scn_external;
    srst = 1'b1;
    mode = 1'b0;
    cyc(16);
    srst = 1'b0;
    cyc(8);
    xfer(1'b1, 1'b0, BITS_LONG, 24'h6b2d19);
    check(ctrl_reg, 24'h6b2d19);
    xfer(1'b0, 1'b0, BITS_LONG, 24'h0);
    check(got, 24'h6b2d19);
    check(24'(rsp_err), 24'h0);
  endtask

  initial begin
    fails       = 0;
    check_count = 0;
    srst        = 1'b1;
    mode        = 1'b1;
    conv_valid  = 1'b0;
    conv_long   = 1'b1;
    cal_access  = 1'b0;
    cmd_read    = 1'b0;
    cmd_write   = 1'b0;
    cyc(16);
    srst = 1'b0;
    cyc(8);
    scn_write;
    scn_read;
    scn_output;
    scn_dropped;
    scn_external;
    tally_and_finish;
  end
endmodule // adc_serial_port_self_clocked_test
